// ==== src/ssrs_top.sv ====
// supply selection, hard reset and system reset supervisor with axi4-lite
`timescale 1ns/1ps
// Function
// [RL1] both supplies present: run from primary
// [RL2] primary appears on vbus: switch without reset
// [RL3] primary lost with vbus: hard reset, reboot
// [RL4] vbus only: run from regulator, dead battery
// [RL5] circuitry held off until supply good
// [RL6] core enables output switch under programmable conditions
// [RL7] programmable supervisor watches switched output
// [RL8] under-voltage drives system reset low
// [RL9] asserted manual reset drives system reset low
// [RL10] manual reset active high, configurable active low
// [RL11] release reset only when both causes clear
module ssrs_top
  import ssrs_pkg::*;
#(
  parameter int unsigned POR_CNT = POR_QUAL_CYC
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // analog comparators
  input  wire logic              primary_3v3_supply,
  input  wire logic              vbus_present,
  input  wire logic              vout_uv,
  // board side
  input  wire logic              manual_reset_in,
  output logic                   system_reset_out_n,
  // power path control
  output logic                   sel_primary,
  output logic                   core_run,
  output logic                   hard_reset,
  output logic                   dead_battery,
  output logic                   output_supply_switch,
  output logic [SUPV_W-1:0]      uv_threshold
);
  // ---------------------------------------------------------------
  // supply qualification
  // ---------------------------------------------------------------
  logic [1:0] sup_raw;
  logic [1:0] sup_ok;
  assign sup_raw = {vbus_present, primary_3v3_supply};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_por
      ssrs_por_qual #(.CNT(POR_CNT)) u_qual (
        .aclk    (aclk),
        .aresetn (aresetn),
        .present (sup_raw[gi]),
        .good    (sup_ok[gi])
      );
    end
  endgenerate

  logic vin_ok;
  logic vbus_ok;
  assign vin_ok  = sup_ok[0];
  assign vbus_ok = sup_ok[1];

  // ---------------------------------------------------------------
  // registers and bus handshake
  // ---------------------------------------------------------------
  ssrs_ctrl_t          ctrl_r;
  logic [SUPV_W-1:0]   supv_r;
  logic [EVT_W-1:0]    evt_r;
  logic                aw_held_r;
  logic                w_held_r;
  logic [ADDR_W-1:0]   awaddr_r;
  logic [31:0]         wdata_r;
  logic [3:0]          wstrb_r;
  logic                wr_fire;
  ssrs_rsel_t          wsel;
  ssrs_state_t         state_r;
  logic                sel_pri_r;
  logic [HRST_CW-1:0]  hcnt_r;
  logic                swov_ev;
  logic                hrst_ev;
  logic                mrst_act;
  ssrs_stat_t          stat;

  // one decoder serves both read and write paths
  function automatic ssrs_rsel_t dec(input logic [ADDR_W-1:0] a);
    if (a == OFS_CTRL) begin
      dec = RS_CTRL;
    end else if (a == OFS_SUPV) begin
      dec = RS_SUPV;
    end else if (a == OFS_STAT) begin
      dec = RS_STAT;
    end else if (a == OFS_EVT) begin
      dec = RS_EVT;
    end else begin
      dec = RS_NONE;
    end
  endfunction

  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wsel          = dec(awaddr_r);

  // address and data are latched separately, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wsel == RS_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // control and supervisor threshold; only byte lane 0 carries bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      supv_r <= SUPV_RST;
    end else if (wr_fire && wstrb_r[0]) begin
      if (wsel == RS_CTRL) begin
        ctrl_r <= wdata_r[CTRL_W-1:0];  // [RL10] [RL6]
      end else if (wsel == RS_SUPV) begin
        supv_r <= wdata_r[SUPV_W-1:0];  // [RL7]
      end
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_r <= '0;
    end else begin
      if (wr_fire && wstrb_r[0] && wsel == RS_EVT) begin
        evt_r <= (evt_r & ~wdata_r[EVT_W-1:0]) | {swov_ev, hrst_ev};
      end else begin
        evt_r <= evt_r | {swov_ev, hrst_ev};
      end
    end
  end

  assign stat = '{out_sw: output_supply_switch, rst_out_n: system_reset_out_n,
                  mrst: mrst_act, uv: vout_uv, dead_bat: dead_battery,
                  sel_pri: sel_pri_r, st: state_r};

  // read path answers in the cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (dec(s_axi_araddr))
        RS_CTRL: s_axi_rdata <= {29'h0, ctrl_r};
        RS_SUPV: s_axi_rdata <= {28'h0, supv_r};
        RS_STAT: s_axi_rdata <= {24'h0, stat};
        RS_EVT:  s_axi_rdata <= {30'h0, evt_r};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // supply sequencer
  // ---------------------------------------------------------------
  logic pri_lost;
  assign pri_lost = sel_pri_r && !vin_ok && vbus_ok;
  assign swov_ev  = (state_r == ST_RUN) && !sel_pri_r && vin_ok;
  assign hrst_ev  = (state_r == ST_RUN) && pri_lost;

  // the hard reset holds for a fixed time so every consumer sees it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r   <= ST_OFF;
      sel_pri_r <= 1'b0;
      hcnt_r    <= '0;
    end else begin
      case (state_r)
        ST_OFF: begin
          if (|sup_raw) begin
            state_r <= ST_POR;
          end
        end
        ST_POR: begin
          if (vin_ok || vbus_ok) begin
            state_r   <= ST_RUN;               // [RL5]
            sel_pri_r <= vin_ok;               // [RL1] [RL4]
          end else if (!(|sup_raw)) begin
            state_r <= ST_OFF;
          end
        end
        ST_RUN: begin
          if (pri_lost) begin
            state_r <= ST_HRST;                // [RL3]
            hcnt_r  <= '0;
          end else if (vin_ok) begin
            sel_pri_r <= 1'b1;                 // [RL1] [RL2]
          end else if (vbus_ok) begin
            sel_pri_r <= 1'b0;                 // [RL4]
          end else begin
            state_r <= ST_OFF;
          end
        end
        ST_HRST: begin
          sel_pri_r <= 1'b0;
          if (hcnt_r == HRST_CW'(HRST_CYC - 1)) begin
            state_r <= ST_OFF;                 // [RL3]
          end else begin
            hcnt_r <= hcnt_r + 1'b1;
          end
        end
        default: state_r <= ST_OFF;
      endcase
    end
  end

  assign sel_primary  = sel_pri_r;
  assign core_run     = (state_r == ST_RUN);   // [RL5]
  assign hard_reset   = (state_r == ST_HRST);
  assign dead_battery = core_run && !sel_pri_r;  // [RL4]
  assign uv_threshold = supv_r;                // [RL7]

  // ---------------------------------------------------------------
  // output switch and system reset
  // ---------------------------------------------------------------
  assign mrst_act = manual_reset_in ^ ctrl_r.mrst_low;  // [RL10]

  // switch closes only while running from a good primary supply
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_supply_switch <= 1'b0;
    end else begin
      output_supply_switch <= core_run && vin_ok && ctrl_r.sw_en &&
                              !(ctrl_r.sw_hold_mrst && mrst_act);  // [RL6]
    end
  end

  // reset stays low from bus reset until both causes are clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_reset_out_n <= 1'b0;
    end else begin
      system_reset_out_n <= !(vout_uv || mrst_act);  // [RL8] [RL9] [RL11]
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_pri_pref;
    @(posedge aclk) disable iff (!aresetn)
    core_run && vin_ok && !pri_lost |=> sel_primary;
  endproperty
  a_pri_pref: assert property (p_pri_pref) else $error("primary not preferred");  // RL1

  property p_swover;
    @(posedge aclk) disable iff (!aresetn)
    core_run && !sel_primary && vin_ok |=> core_run && sel_primary && !hard_reset;
  endproperty
  a_swover: assert property (p_swover) else $error("switch-over caused reset");  // RL2

  property p_hrst;
    @(posedge aclk) disable iff (!aresetn)
    core_run && sel_primary && !vin_ok && vbus_ok |=> hard_reset [*8] ##1 !core_run;
  endproperty
  a_hrst: assert property (p_hrst) else $error("no hard reset on primary loss");  // RL3

  property p_dead;
    @(posedge aclk) disable iff (!aresetn)
    core_run && !vin_ok && vbus_ok && !sel_primary |=> dead_battery && core_run;
  endproperty
  a_dead: assert property (p_dead) else $error("vbus run not flagged");  // RL4

  property p_por;
    @(posedge aclk) disable iff (!aresetn)
    $rose(core_run) |-> $past(vin_ok || vbus_ok);
  endproperty
  a_por: assert property (p_por) else $error("core started without good supply");  // RL5

  property p_sw;
    @(posedge aclk) disable iff (!aresetn)
    output_supply_switch |-> $past(ctrl_r.sw_en && vin_ok && core_run);
  endproperty
  a_sw: assert property (p_sw) else $error("switch closed without enable");  // RL6

  property p_supv;
    @(posedge aclk) disable iff (!aresetn)
    $changed(uv_threshold) |-> $past(wr_fire && wsel == RS_SUPV);
  endproperty
  a_supv: assert property (p_supv) else $error("threshold changed without write");  // RL7

  property p_uv;
    @(posedge aclk) disable iff (!aresetn)
    vout_uv |=> !system_reset_out_n;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage did not reset");  // RL8

  property p_mrst;
    @(posedge aclk) disable iff (!aresetn)
    (manual_reset_in != ctrl_r.mrst_low) |=> !system_reset_out_n;
  endproperty
  a_mrst: assert property (p_mrst) else $error("manual reset ignored");  // RL9

  property p_release;
    @(posedge aclk) disable iff (!aresetn)
    aresetn && !vout_uv && !mrst_act |=> system_reset_out_n;
  endproperty
  a_release: assert property (p_release) else $error("reset not released");  // RL11

  c_swover: cover property (@(posedge aclk) disable iff (!aresetn) swov_ev);
  c_hrst:   cover property (@(posedge aclk) disable iff (!aresetn) hrst_ev);
  c_dead:   cover property (@(posedge aclk) disable iff (!aresetn) dead_battery);
  c_mlow:   cover property (@(posedge aclk) disable iff (!aresetn)
                            ctrl_r.mrst_low && !system_reset_out_n && !vout_uv);
endmodule

// ==== shared/ssrs_pkg.sv ====
// constants and types shared by the supply select and reset supervisor
package ssrs_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned POR_QUAL_NS   = 10000;  // least stable time
  localparam int unsigned POR_QUAL_CYC  = (POR_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HRST_NS       = 1000;   // least hard reset pulse
  localparam int unsigned HRST_CYC      = (HRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HRST_CW       = $clog2(HRST_CYC + 1);

  // ---------------------------------------------------------------
  // register map, byte addresses
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W   = 4;
  localparam logic [3:0]  OFS_CTRL = 4'h0;
  localparam logic [3:0]  OFS_SUPV = 4'h4;
  localparam logic [3:0]  OFS_STAT = 4'h8;
  localparam logic [3:0]  OFS_EVT  = 4'hC;

  localparam int unsigned CTRL_W        = 3;
  localparam logic [2:0]  CTRL_RST      = 3'h0;  // manual reset active high
  localparam int unsigned SUPV_W        = 4;
  localparam logic [3:0]  SUPV_RST      = 4'h8;
  localparam int unsigned EVT_W         = 2;
  localparam int unsigned EVT_HRST_BIT  = 0;
  localparam int unsigned EVT_SWOV_BIT  = 1;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_OFF  = 2'h0,
    ST_POR  = 2'h1,
    ST_RUN  = 2'h3,
    ST_HRST = 2'h2
  } ssrs_state_t;

  typedef enum logic [2:0] {
    RS_CTRL = 3'h0,
    RS_SUPV = 3'h1,
    RS_STAT = 3'h2,
    RS_EVT  = 3'h3,
    RS_NONE = 3'h4
  } ssrs_rsel_t;

  // bit 2 opens the switch while manual reset is held, bit 0 polarity
  typedef struct packed {
    logic sw_hold_mrst;
    logic sw_en;
    logic mrst_low;
  } ssrs_ctrl_t;

  typedef struct packed {
    logic        out_sw;
    logic        rst_out_n;
    logic        mrst;
    logic        uv;
    logic        dead_bat;
    logic        sel_pri;
    ssrs_state_t st;
  } ssrs_stat_t;
endpackage

// ==== src/ssrs_por_qual.sv ====
// power-on qualifier: a supply counts as good after staying present
`timescale 1ns/1ps
module ssrs_por_qual
  import ssrs_pkg::*;
#(
  parameter int unsigned CNT = POR_QUAL_CYC
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // comparator level and qualified result
  input  wire logic present,
  output logic      good
);
  localparam int unsigned CW = $clog2(CNT + 1);
  localparam logic [CW-1:0] LAST = CW'(CNT - 1);

  logic [CW-1:0] cnt_r;

  // count stable cycles; a drop clears at once so loss is never delayed
  always_ff @(posedge aclk) begin
    if (!aresetn || !present) begin
      cnt_r <= '0;
      good  <= 1'b0;
    end else if (!good) begin
      if (cnt_r == LAST) begin
        good <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule

// ==== bench/ssrs_board_model.sv ====
// board side model: manual reset source and a reset consumer
`timescale 1ns/1ps
module ssrs_board_model (
  // clock
  input  wire logic aclk,
  // commands from the bench
  input  wire logic mrst_req,
  input  wire logic active_low,
  // pins toward the device
  output logic      manual_reset_in,
  input  wire logic system_reset_out_n,
  // consumer view
  output logic      board_held
);
  // -------------------------------------------------------------
  // manual reset source
  // -------------------------------------------------------------
  // the source drives whichever polarity the device was set up for
  assign manual_reset_in = mrst_req ^ active_low;

  // -------------------------------------------------------------
  // reset consumer
  // -------------------------------------------------------------
  // consumers sample the reset line on the board clock
  always_ff @(posedge aclk) begin
    board_held <= !system_reset_out_n;
  end
endmodule

// ==== bench/ssrs_top_test.sv ====
// self-checking testbench for the supply select and reset supervisor
`timescale 1ns/1ps
module ssrs_top_test;
  import ssrs_pkg::*;
  localparam int unsigned PC = 4;  // short qualify count for simulation

  // -------------------------------------------------------------
  // signals
  // -------------------------------------------------------------
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic              arvalid = 1'b0, rready = 1'b0;
  logic [31:0]       wdata = '0;
  logic [3:0]        wstrb = 4'h0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp;
  logic [31:0]       rdata;
  logic              pri = 1'b0, vbus = 1'b0, uv = 1'b0;
  logic              mrst_req = 1'b0, act_low = 1'b0, mrst_pin, held;
  logic              rst_n, sel_pri, core_run, hard_rst, dead_bat, out_sw;
  logic [SUPV_W-1:0] thr;
  int                mismatches = 0;
  int                checks_done = 0;
  logic [31:0]       rd;
  int                cnt;

  always #5 aclk = ~aclk;

  ssrs_top #(.POR_CNT(PC)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .primary_3v3_supply(pri), .vbus_present(vbus), .vout_uv(uv),
    .manual_reset_in(mrst_pin), .system_reset_out_n(rst_n),
    .sel_primary(sel_pri), .core_run(core_run), .hard_reset(hard_rst),
    .dead_battery(dead_bat), .output_supply_switch(out_sw), .uv_threshold(thr)
  );

  ssrs_board_model i_board (
    .aclk(aclk), .mrst_req(mrst_req), .active_low(act_low),
    .manual_reset_in(mrst_pin), .system_reset_out_n(rst_n), .board_held(held)
  );

  // -------------------------------------------------------------
  // reporting
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic timed_out();
    mismatches++;
    $display("mismatch at %0t: seen %h expected %h", $time, 32'h0, 32'h1);
    complete_run();
  endtask

  // wait n edges, then sample where outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  // -------------------------------------------------------------
  // axi4-lite master
  // -------------------------------------------------------------
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d,
                        input logic [1:0] er = RESP_OKAY);
    logic ta, tw, ad, wd;
    int   n;
    ad = 1'b0;
    wd = 1'b0;
    n = 0;
    @(posedge aclk);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      if (ta) begin awvalid <= 1'b0; ad = 1'b1; end
      if (tw) begin wvalid <= 1'b0; wd = 1'b1; end
      if (++n > 50) timed_out();
    end
    // bready stays high until the response is seen
    forever begin
      @(negedge aclk);
      ta = bvalid;
      @(posedge aclk);
      if (ta) begin bready <= 1'b0; break; end
      if (++n > 100) timed_out();
    end
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d,
                        input logic [1:0] er = RESP_OKAY);
    logic       t;
    logic [1:0] rs;
    int         n;
    n = 0;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    forever begin
      @(negedge aclk);
      t = arready;
      @(posedge aclk);
      if (t) begin arvalid <= 1'b0; break; end
      if (++n > 50) timed_out();
    end
    forever begin
      @(negedge aclk);
      t = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge aclk);
      if (t) begin rready <= 1'b0; break; end
      if (++n > 100) timed_out();
    end
    // response code is taken with the data, in the cycle where rvalid stands
    chk({30'h0, rs}, {30'h0, er});
  endtask

  // -------------------------------------------------------------
  // main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(OFS_CTRL, rd); chk(rd, {29'h0, CTRL_RST});
    axi_rd(OFS_SUPV, rd); chk(rd, {28'h0, SUPV_RST});
    // vbus only: held off until qualified, then dead battery run
    @(posedge aclk); vbus <= 1'b1;
    cyc(2); chk(core_run, 1'b0);
    cyc(PC + 6); chk({core_run, sel_pri, dead_bat}, 3'b101);
    $display("test vbus start done");
    // primary arrives: switch over without dropping the core
    @(posedge aclk); pri <= 1'b1;
    cnt = 0;
    repeat (PC + 6) begin @(negedge aclk); if (core_run !== 1'b1) cnt++; end
    chk(cnt, 0);
    chk({sel_pri, dead_bat}, 2'b10);
    axi_rd(OFS_EVT, rd); chk(rd, 32'h2);
    axi_wr(OFS_EVT, 32'h3);
    axi_rd(OFS_EVT, rd); chk(rd, 32'h0);
    axi_rd(OFS_STAT, rd); chk(rd, 32'h47);
    $display("test switch-over done");
    // output switch enable and hold while manual reset is asserted
    axi_wr(OFS_CTRL, 32'h2);
    cyc(3); chk({out_sw, rst_n}, 2'b11);
    axi_wr(OFS_CTRL, 32'h6);
    @(posedge aclk); mrst_req <= 1'b1;
    cyc(3); chk({out_sw, rst_n, held}, 3'b001);
    @(posedge aclk); mrst_req <= 1'b0;
    cyc(3); chk({out_sw, rst_n, held}, 3'b110);
    $display("test output switch done");
    // manual reset polarity turned to active low
    axi_wr(OFS_CTRL, 32'h3);
    @(posedge aclk); act_low <= 1'b1;
    cyc(3); chk(rst_n, 1'b1);
    @(posedge aclk); mrst_req <= 1'b1;
    cyc(3); chk(rst_n, 1'b0);
    @(posedge aclk); mrst_req <= 1'b0;
    cyc(3); chk(rst_n, 1'b1);
    $display("test polarity done");
    // under-voltage on the switched output
    @(posedge aclk); uv <= 1'b1;
    cyc(2); chk(rst_n, 1'b0);
    axi_rd(OFS_STAT, rd); chk(rd[6:4], 3'b001);
    @(posedge aclk); uv <= 1'b0;
    cyc(2); chk(rst_n, 1'b1);
    axi_wr(OFS_SUPV, 32'h3);
    cyc(1); chk(thr, 4'h3);
    axi_rd(OFS_SUPV, rd); chk(rd, 32'h3);
    $display("test supervisor done");
    // primary lost with vbus present: hard reset then reboot on vbus
    @(posedge aclk); pri <= 1'b0;
    cnt = 0;
    repeat (300) begin @(negedge aclk); if (hard_rst === 1'b1) cnt++; end
    chk(cnt, HRST_CYC);
    chk({core_run, sel_pri, dead_bat, out_sw}, 4'b1010);
    axi_rd(OFS_EVT, rd); chk(rd[0], 1'b1);
    $display("test hard reset done");
    // second reset with both supplies up: primary chosen
    @(posedge aclk); aresetn <= 1'b0; pri <= 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(PC + 6); chk({core_run, sel_pri, dead_bat}, 3'b110);
    // unmapped offset: write dropped with slverr, read gives zero and slverr
    axi_wr(4'h2, 32'h7, RESP_SLVERR);
    axi_rd(4'h2, rd, RESP_SLVERR); chk(rd, 32'h0);
    axi_rd(OFS_CTRL, rd); chk(rd, 32'h0);
    $display("test both supplies done");
    complete_run();
  end

  // overall guard against a hang
  initial begin
    repeat (20000) @(posedge aclk);
    timed_out();
  end
endmodule
